// File: vpic_top.sv
// Vectored priority interrupt controller with daisy chain and register port.
//
// Notes on behaviour
// - Sixteen channels, line 15 highest, line 0 lowest.
// - Channel codes 15 to 8 for upper group.
// - Channel codes 7 to 0 for lower group.
// - Acknowledge supplies highest pending channel's vector.
// - Masked channels are skipped during ranking.
// - Vector low nibble is channel number.
// - Vector high nibble from vector register.
// - Enable bits written and readable any time.
// - Enabled channel event asserts active-low request if unmasked and above any in-service channel.
// - Disabled channel events are ignored entirely.
// - Writing enable zero clears pending bit.
// - Disabling leaves in-service bit untouched.
// - All chained devices resolve priority concurrently.
// - Chain in, nothing pending: pass chain on.
// - Chain in with pending: supply vector, hold chain.
// - Drive vector, then assert transfer acknowledge.
// - Passing device drives neither data nor acknowledge.
// - Reset: vector register 0F, channels cleared.
// - Supplied vector clears its pending bit.
`timescale 1ns/10ps
`include "vpic_cfg.svh"
module vpic_top (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [`VPIC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt sources, one pulse per event, index is channel number.
  input wire logic [15:0] i_chan_event,
  // Processor side of the acknowledge cycle.
  output logic o_irq_n,
  input wire logic i_irq_acknowledge_in_n,
  input wire logic i_data_strobe_n,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_transfer_acknowledge_n,
  output logic o_transfer_acknowledge_oe,
  // Daisy chain.
  input wire logic i_chain_enable_in_n,
  output logic o_chain_enable_out_n
);
  // -------------------------------------------------------------------
  // State and resolver
  // -------------------------------------------------------------------
  vpic_pkg::vpic_state_type r_reg; // Current state.
  vpic_pkg::vpic_state_type r_next; // Next state.
  logic res_any; // Some channel may be served now.
  logic [3:0] res_chan; // Winning channel number.
  logic ack_active; // Acknowledge and strobe both asserted.
  logic wr_ena_a; // Write to enable register A.
  logic wr_ena_b; // Write to enable register B.
  logic [15:0] dis_clr; // Channels whose enable bit is written zero.
  logic [15:0] sw_pend_clr; // Pending bits cleared by software.
  logic [15:0] sw_isr_clr; // In-service bits cleared by software.
  logic [15:0] ack_clr; // Pending bit cleared by a supplied vector.
  logic [15:0] isr_set; // In-service bit set by a supplied vector.

  // Resolver runs all the time, so every chained part ranks concurrently.
  vpic_prio u_prio (
    .i_pending(r_reg.pending),
    .i_mask(r_reg.mask),
    .i_in_service(r_reg.in_service),
    .o_any(res_any),
    .o_chan(res_chan)
  );

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  // Register writes, pending and in-service updates and the acknowledge
  // sequencer all fill one copy of the state.
  always_comb begin
    r_next = r_reg;
    ack_active = !i_irq_acknowledge_in_n && !i_data_strobe_n;
    wr_ena_a = i_wr && (i_addr == `VPIC_OFF_ENABLE_A);
    wr_ena_b = i_wr && (i_addr == `VPIC_OFF_ENABLE_B);
    dis_clr = 16'h0000;
    sw_pend_clr = 16'h0000;
    sw_isr_clr = 16'h0000;
    ack_clr = 16'h0000;
    isr_set = 16'h0000;
    // Enable writes; a zero bit also clears the pending bit.
    if (wr_ena_a) begin
      r_next.enable[15:8] = i_wdata;
      dis_clr[15:8] = ~i_wdata;
    end
    if (wr_ena_b) begin
      r_next.enable[7:0] = i_wdata;
      dis_clr[7:0] = ~i_wdata;
    end
    // Pending and in-service registers clear on zero, ones are ignored.
    if (i_wr && (i_addr == `VPIC_OFF_PENDING_A)) begin
      sw_pend_clr[15:8] = ~i_wdata;
    end
    if (i_wr && (i_addr == `VPIC_OFF_PENDING_B)) begin
      sw_pend_clr[7:0] = ~i_wdata;
    end
    if (i_wr && (i_addr == `VPIC_OFF_IN_SERVICE_A)) begin
      sw_isr_clr[15:8] = ~i_wdata;
    end
    if (i_wr && (i_addr == `VPIC_OFF_IN_SERVICE_B)) begin
      sw_isr_clr[7:0] = ~i_wdata;
    end
    // Mask and vector base registers store the written byte.
    if (i_wr && (i_addr == `VPIC_OFF_MASK_A)) begin
      r_next.mask[15:8] = i_wdata;
    end
    if (i_wr && (i_addr == `VPIC_OFF_MASK_B)) begin
      r_next.mask[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == `VPIC_OFF_VECTOR_BASE)) begin
      r_next.vector_base = i_wdata;
    end
    // Read data stands in the cycle after the read strobe only.
    r_next.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        `VPIC_OFF_ENABLE_A: r_next.rdata = r_reg.enable[15:8];
        `VPIC_OFF_ENABLE_B: r_next.rdata = r_reg.enable[7:0];
        `VPIC_OFF_PENDING_A: r_next.rdata = r_reg.pending[15:8];
        `VPIC_OFF_PENDING_B: r_next.rdata = r_reg.pending[7:0];
        `VPIC_OFF_IN_SERVICE_A: r_next.rdata = r_reg.in_service[15:8];
        `VPIC_OFF_IN_SERVICE_B: r_next.rdata = r_reg.in_service[7:0];
        `VPIC_OFF_MASK_A: r_next.rdata = r_reg.mask[15:8];
        `VPIC_OFF_MASK_B: r_next.rdata = r_reg.mask[7:0];
        `VPIC_OFF_VECTOR_BASE: r_next.rdata = r_reg.vector_base;
        default: r_next.rdata = 8'h00;
      endcase
    end
    // Acknowledge sequencer.
    unique case (r_reg.state)
      vpic_pkg::ST_IDLE: begin
        // The winner is frozen at the start of the cycle.
        if (ack_active) begin
          r_next.have_win = res_any;
          r_next.win_chan = res_chan;
          r_next.state = vpic_pkg::ST_WAIT_CHAIN;
        end
      end
      vpic_pkg::ST_WAIT_CHAIN: begin
        if (!ack_active) begin
          r_next.state = vpic_pkg::ST_IDLE;
        end else if (!i_chain_enable_in_n && r_reg.have_win) begin
          // Drive the vector now, acknowledge one cycle later.
          r_next.state = vpic_pkg::ST_SUPPLY;
          r_next.vec_out = {r_reg.vector_base[`VPIC_VEC_BASE_MSB:`VPIC_VEC_BASE_LSB],
                            r_reg.win_chan};
          r_next.data_oe = 1'b1;
          ack_clr[r_reg.win_chan] = 1'b1;
          if (r_reg.vector_base[`VPIC_VEC_SOFT_EOI_BIT]) begin
            isr_set[r_reg.win_chan] = 1'b1;
          end
        end else if (!i_chain_enable_in_n) begin
          r_next.state = vpic_pkg::ST_PASS;
          r_next.chain_out = 1'b1;
        end
      end
      vpic_pkg::ST_SUPPLY: begin
        if (!ack_active) begin
          r_next.state = vpic_pkg::ST_IDLE;
          r_next.data_oe = 1'b0;
          r_next.transfer_acknowledge = 1'b0;
        end else begin
          r_next.transfer_acknowledge = 1'b1;
        end
      end
      vpic_pkg::ST_PASS: begin
        // A passing device keeps off the data bus and acknowledge.
        if (!ack_active) begin
          r_next.state = vpic_pkg::ST_IDLE;
          r_next.chain_out = 1'b0;
        end
      end
    endcase
    // Events on enabled channels set pending; a set wins over any clear.
    r_next.pending = (r_reg.pending & ~dis_clr & ~sw_pend_clr & ~ack_clr)
                     | (i_chan_event & r_next.enable);
    // Disabling does not touch in-service; only software clears it.
    r_next.in_service = (r_reg.in_service & ~sw_isr_clr) | isr_set;
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  // Reset clears channels and loads the vector base reset value.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg.enable <= `VPIC_RST_CHANNELS;
      r_reg.pending <= `VPIC_RST_CHANNELS;
      r_reg.in_service <= `VPIC_RST_CHANNELS;
      r_reg.mask <= `VPIC_RST_CHANNELS;
      r_reg.vector_base <= `VPIC_RST_VECTOR_BASE;
      r_reg.rdata <= `VPIC_RST_BYTE;
      r_reg.state <= vpic_pkg::ST_IDLE;
      r_reg.have_win <= 1'b0;
      r_reg.win_chan <= 4'h0;
      r_reg.vec_out <= `VPIC_RST_BYTE;
      r_reg.data_oe <= 1'b0;
      r_reg.transfer_acknowledge <= 1'b0;
      r_reg.chain_out <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  // Request is low while any channel may be served.
  assign o_irq_n = !res_any;
  assign o_rdata = r_reg.rdata;
  assign o_data = r_reg.vec_out;
  assign o_data_oe = r_reg.data_oe;
  // Acknowledge is driven low only while this device answers.
  assign o_transfer_acknowledge_n = !r_reg.transfer_acknowledge;
  assign o_transfer_acknowledge_oe = r_reg.transfer_acknowledge;
  assign o_chain_enable_out_n = !r_reg.chain_out;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // Chain input with nothing to serve passes the chain on next cycle.
  a_chain_pass_on: assert property (
    (r_reg.state == vpic_pkg::ST_WAIT_CHAIN) && !r_reg.have_win
    && !i_chain_enable_in_n && !i_irq_acknowledge_in_n && !i_data_strobe_n
    |=> !o_chain_enable_out_n)
    else $error("Chain was not passed on with nothing pending.");

  // A device that supplies its vector holds the chain output.
  a_supply_holds_chain: assert property (
    o_data_oe |-> o_chain_enable_out_n)
    else $error("Chain output asserted while supplying a vector.");

  // A passing device drives neither data nor acknowledge.
  a_pass_no_drive: assert property (
    !o_chain_enable_out_n |-> !o_data_oe && !o_transfer_acknowledge_oe)
    else $error("Passing device drives the bus.");

  // Low nibble of the vector is the frozen winning channel.
  a_vector_low_chan: assert property (
    o_data_oe |-> o_data[3:0] == r_reg.win_chan)
    else $error("Vector low nibble differs from the winning channel.");

  // High nibble of the vector is the programmed base.
  a_vector_high_base: assert property (
    $rose(o_data_oe) |-> o_data[7:4] == $past(r_reg.vector_base[7:4]))
    else $error("Vector high nibble differs from the base register.");

  // Acknowledge follows the data by one cycle.
  a_transfer_acknowledge_after_data: assert property (
    $rose(o_data_oe) |-> !o_transfer_acknowledge_oe
    ##1 (o_transfer_acknowledge_oe || !o_data_oe))
    else $error("Acknowledge not asserted one cycle after the data.");

  // No disabled channel ever holds a pending bit.
  a_disabled_no_pend: assert property (
    (r_reg.pending & ~r_reg.enable) == 16'h0000)
    else $error("Disabled channel is pending.");

  // A supplied vector clears its pending bit unless a new event came.
  a_ack_clears_pend: assert property (
    $rose(o_data_oe) && !$past(i_chan_event[r_reg.win_chan])
    |-> !r_reg.pending[r_reg.win_chan])
    else $error("Pending bit not cleared by the supplied vector.");

  // Unmasked pending with nothing in service requests service.
  a_irq_on_pending: assert property (
    ((r_reg.pending & r_reg.mask) != 16'h0000) && (r_reg.in_service == 16'h0000)
    |-> !o_irq_n)
    else $error("Request not asserted with a pending channel.");

  // The winner stays frozen until the cycle ends.
  a_winner_stable: assert property (
    (r_reg.state != vpic_pkg::ST_IDLE) && ($past(r_reg.state) != vpic_pkg::ST_IDLE)
    |-> $stable(r_reg.win_chan) && $stable(r_reg.have_win))
    else $error("Winner changed during an acknowledge cycle.");

  // The frozen winner is the resolver result at cycle start.
  a_winner_highest: assert property (
    (r_reg.state == vpic_pkg::ST_IDLE) && !i_irq_acknowledge_in_n && !i_data_strobe_n
    |=> r_reg.win_chan == $past(res_chan) && r_reg.have_win == $past(res_any))
    else $error("Frozen winner is not the highest eligible channel.");

  // Read data returns to zero outside the cycle after a read strobe.
  a_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("Read data not zero outside a read cycle.");
endmodule

// File: vpic_cfg.svh
// Register offsets, field positions and reset values of the interrupt controller.
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH
`define VPIC_ADDR_W 5
`define VPIC_OFF_ENABLE_A 5'h00
`define VPIC_OFF_ENABLE_B 5'h01
`define VPIC_OFF_PENDING_A 5'h02
`define VPIC_OFF_PENDING_B 5'h03
`define VPIC_OFF_IN_SERVICE_A 5'h04
`define VPIC_OFF_IN_SERVICE_B 5'h05
`define VPIC_OFF_MASK_A 5'h06
`define VPIC_OFF_MASK_B 5'h07
`define VPIC_OFF_VECTOR_BASE 5'h08
`define VPIC_VEC_BASE_MSB 7
`define VPIC_VEC_BASE_LSB 4
`define VPIC_VEC_SOFT_EOI_BIT 3
`define VPIC_RST_VECTOR_BASE 8'h0f
`define VPIC_RST_CHANNELS 16'h0000
`define VPIC_RST_BYTE 8'h00
`endif

// File: vpic_pkg.sv
// Types shared by the interrupt controller modules.
package vpic_pkg;
  // Acknowledge cycle sequencer, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_CHAIN = 4'b0010,
    ST_SUPPLY = 4'b0100,
    ST_PASS = 4'b1000
  } vpic_fsm_type;

  // Whole state of the controller.
  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] pending;
    logic [15:0] in_service;
    logic [15:0] mask;
    logic [7:0] vector_base;
    logic [7:0] rdata;
    vpic_fsm_type state;
    logic have_win;
    logic [3:0] win_chan;
    logic [7:0] vec_out;
    logic data_oe;
    logic transfer_acknowledge;
    logic chain_out;
  } vpic_state_type;

  // Highest set bit of a channel vector: found flag and index.
  function automatic logic [4:0] vpic_highest(input logic [15:0] v);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction
endpackage

// File: vpic_prio.sv
// Fixed-priority resolver that picks the winning interrupt channel.
`timescale 1ns/10ps
module vpic_prio (
  // Channel state.
  input wire logic [15:0] i_pending,
  input wire logic [15:0] i_mask,
  input wire logic [15:0] i_in_service,
  // Resolution result.
  output logic o_any,
  output logic [3:0] o_chan
);
  // Channels at or below the highest in-service channel are held back.
  logic [4:0] isr_top;
  logic [15:0] above;
  logic [15:0] eligible;
  logic [4:0] win;

  // Builds the set of channels allowed to request, then ranks them.
  always_comb begin
    isr_top = vpic_pkg::vpic_highest(i_in_service);
    for (int i = 0; i < 16; i++) begin
      above[i] = !isr_top[4] || (5'(i) > {1'b0, isr_top[3:0]});
    end
    eligible = i_pending & i_mask & above;
    win = vpic_pkg::vpic_highest(eligible);
    o_any = win[4];
    o_chan = win[3:0];
  end
endmodule

// File: vpic_host.sv
// Host processor model that runs vectored interrupt acknowledge cycles.
`timescale 1ns/10ps
module vpic_host (
  // Clock.
  input wire logic i_mclk,
  // Device answer on the shared bus.
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_transfer_acknowledge_n,
  input wire logic i_transfer_acknowledge_oe,
  input wire logic i_chain_out_n,
  // Acknowledge cycle drive.
  output logic o_ack_n,
  output logic o_ds_n,
  output logic o_chain_in_n
);
  // The bus idles with no acknowledge and the upstream chain not granting.
  initial begin
    o_ack_n = 1'b1;
    o_ds_n = 1'b1;
    o_chain_in_n = 1'b1;
  end

  // -------------------------------------------------------------------
  // One acknowledge cycle; dly keeps the upstream chain busy that long.
  // -------------------------------------------------------------------
  task automatic ack(input int dly, output logic got, output logic passed,
                     output logic bad, output logic [7:0] vec);
    int n;
    logic early;
    logic drove;
    n = 0;
    got = 1'b0;
    passed = 1'b0;
    early = 1'b0;
    drove = 1'b0;
    vec = 8'h00;
    @(posedge i_mclk);
    o_ack_n <= 1'b0;
    o_ds_n <= 1'b0;
    o_chain_in_n <= (dly == 0) ? 1'b0 : 1'b1;
    while (!got && !passed && n < 40) begin
      @(posedge i_mclk);
      n++;
      // Any drive of the bus counts; drive before the grant is a fault.
      if (i_data_oe || i_transfer_acknowledge_oe) drove = 1'b1;
      if (o_chain_in_n && drove) early = 1'b1;
      if (i_transfer_acknowledge_oe && !i_transfer_acknowledge_n) begin
        got = 1'b1;
        // Data not enabled at acknowledge reads back inverted, so it fails.
        vec = i_data_oe ? i_data : ~i_data;
      end else if (!i_chain_out_n) begin
        passed = 1'b1;
      end
      // Grant only while the cycle goes on; the release below owns the last edge.
      if (!got && !passed && n >= dly) o_chain_in_n <= 1'b0;
    end
    bad = early | (passed & drove);
    // Release everything together and leave one idle cycle.
    o_ack_n <= 1'b1;
    o_ds_n <= 1'b1;
    o_chain_in_n <= 1'b1;
    @(posedge i_mclk);
  endtask
endmodule

// File: vpic_top_tb.sv
// Self-checking testbench of the vectored priority interrupt controller.
`timescale 1ns/10ps
`include "vpic_cfg.svh"
module vpic_top_tb;
  // -------------------------------------------------------------------
  // Signals and expected state.
  // -------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] ev = 16'h0000;
  logic [7:0] rdata, vdata, base, v, vec;
  logic irq_n, ack_n, ds_n, vdata_oe, dt_n, dt_oe, cin_n, cout_n;
  logic [15:0] en, msk, pend, v16;
  logic got, pas, bad;
  logic [4:0] w;
  int fails = 0;
  int n_checks = 0;

  // The clock toggles every 2.5 ns, a period of 5 ns.
  always #2.5 mclk = ~mclk;

  vpic_top i_vpic_top (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_chan_event(ev), .o_irq_n(irq_n),
    .i_irq_acknowledge_in_n(ack_n), .i_data_strobe_n(ds_n), .o_data(vdata),
    .o_data_oe(vdata_oe), .o_transfer_acknowledge_n(dt_n),
    .o_transfer_acknowledge_oe(dt_oe), .i_chain_enable_in_n(cin_n),
    .o_chain_enable_out_n(cout_n));

  vpic_host i_vpic_host (.i_mclk(mclk), .i_data(vdata), .i_data_oe(vdata_oe),
    .i_transfer_acknowledge_n(dt_n), .i_transfer_acknowledge_oe(dt_oe), .i_chain_out_n(cout_n), .o_ack_n(ack_n),
    .o_ds_n(ds_n), .o_chain_in_n(cin_n));

  // -------------------------------------------------------------------
  // Helpers.
  // -------------------------------------------------------------------
  // Highest pending channel: the top bit number wins.
  function automatic logic [4:0] top_chan(input logic [15:0] x);
    top_chan = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) top_chan = {1'b1, 4'(i)};
    end
  endfunction

  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register write, one strobe cycle.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    // One idle edge, so back-to-back writes never lower and raise the strobe at once.
    @(posedge mclk);
  endtask

  // Register read; data stand in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  // Register pairs: channels 15..8 first, then 7..0.
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 5'h01, d[7:0]);
  endtask

  task automatic rd16(input logic [4:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 5'h01, d[7:0]);
  endtask

  // One-cycle event pulse, then one cycle for the request to settle.
  task automatic pulse(input logic [15:0] e);
    ev <= e;
    @(posedge mclk);
    ev <= 16'h0000;
    @(posedge mclk);
  endtask

  // Acknowledge cycle checked against the expected winner.
  task automatic ack_chk(input int dly);
    w = top_chan(pend & msk);
    i_vpic_host.ack(dly, got, pas, bad, vec);
    chk("vector taken", 16'(got), 16'(w[4]));
    chk("chain passed", 16'(pas), 16'(!w[4]));
    chk("bus drive", 16'(bad), 16'h0000);
    if (w[4]) begin
      chk("vector", 16'(vec), 16'({base[7:4], w[3:0]}));
      pend[w[3:0]] = 1'b0;
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected run length.
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    end_sim();
  end

  // -------------------------------------------------------------------
  // Test sequence.
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(32'heb1e8827));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // Reset contents, with one unmapped index at the end.
    for (int a = 0; a < 10; a++) begin
      rd((a == 9) ? 5'h1f : 5'(a), v);
      chk("reset value", 16'(v), (a == 8) ? 16'h000f : 16'h0000);
    end
    chk("reset request", 16'(irq_n), 16'h0001);
    chk("reset bus", 16'({vdata_oe, dt_oe, cout_n}), 16'h0001);
    $display("test reset done");
    // Disabled channels ignore every event.
    en = 16'h0000;
    msk = 16'hffff;
    pend = 16'h0000;
    base = 8'h50;
    wr16(`VPIC_OFF_MASK_A, msk);
    wr(`VPIC_OFF_VECTOR_BASE, base);
    pulse(16'hffff);
    rd16(`VPIC_OFF_PENDING_A, v16);
    chk("pending disabled", v16, 16'h0000);
    chk("request disabled", 16'(irq_n), 16'h0001);
    ack_chk(0);
    $display("test disabled done");
    // Each channel alone gives its own code.
    for (int c = 0; c < 16; c++) begin
      en = 16'h0001 << c;
      wr16(`VPIC_OFF_ENABLE_A, en);
      pulse(16'hffff);
      pend = en;
      chk("request", 16'(irq_n), 16'h0000);
      ack_chk(c % 3);
      chk("request after", 16'(irq_n), 16'h0001);
    end
    $display("test channel codes done");
    // Disabling clears pending but keeps other requests.
    en = 16'hffff;
    wr16(`VPIC_OFF_ENABLE_A, en);
    pulse(16'h8001);
    wr(`VPIC_OFF_ENABLE_B, 8'h00);
    rd16(`VPIC_OFF_PENDING_A, v16);
    chk("pending cleared", v16, 16'h8000);
    chk("request kept", 16'(irq_n), 16'h0000);
    wr(`VPIC_OFF_ENABLE_A, 8'h00);
    @(posedge mclk);
    chk("request ended", 16'(irq_n), 16'h0001);
    $display("test disable clear done");
    // Software end of interrupt: in-service survives disabling.
    base = 8'h68;
    wr(`VPIC_OFF_VECTOR_BASE, base);
    wr(`VPIC_OFF_ENABLE_A, 8'hff);
    pulse(16'h4000);
    pend = 16'h4000;
    ack_chk(1);
    wr(`VPIC_OFF_ENABLE_A, 8'h00);
    rd(`VPIC_OFF_IN_SERVICE_A, v);
    chk("in service kept", 16'(v), 16'h0040);
    wr(`VPIC_OFF_IN_SERVICE_A, 8'hbf);
    $display("test in service done");
    // Random enables, masks and events, drained by acknowledge cycles.
    pend = 16'h0000;
    en = 16'h0000;
    for (int it = 0; it < 30; it++) begin
      en = 16'($urandom());
      msk = 16'($urandom());
      base = {4'($urandom()), 4'h0};
      wr16(`VPIC_OFF_ENABLE_A, en);
      pend &= en;
      wr16(`VPIC_OFF_MASK_A, msk);
      wr(`VPIC_OFF_VECTOR_BASE, base);
      v16 = 16'($urandom());
      pulse(v16);
      pend |= v16 & en;
      rd16(`VPIC_OFF_PENDING_A, v16);
      chk("pending", v16, pend);
      rd16(`VPIC_OFF_ENABLE_A, v16);
      chk("enable", v16, en);
      chk("request", 16'(irq_n), 16'(!(|(pend & msk))));
      do ack_chk(int'($urandom_range(3, 0))); while (w[4]);
      chk("request drained", 16'(irq_n), 16'h0001);
    end
    $display("test random done");
    end_sim();
  end
endmodule
